//--- idc_cfg.sv
// Functional notes
// R1 - The first group command register clears on hardware reset and on a first master clear.
// R2 - Channels 0-3 form the first group, whose requests reach the second group as channel 4.
// R3 - Software writes zero to command bits 7, 6, 5, 3 and 1-0.
// R4 - The acknowledge outputs are always active low, whatever the polarity bit holds.
// R5 - The request inputs are always taken as active high.
// R6 - Command bit 4 is zero during reset (fixed priority); one selects rotating priority.
// R7 - First group command bit 2 set disables service on channels 0-3.
// R8 - The second group command register works the same way for channels 4-7.
// R9 - Second group command bit 2 set stops channels 4-7 and the cascaded first group too.
// R10 - A mode port write stores bits 7-2 into the channel picked by bits 1-0.
// R11 - Mode bits 7-6 pick demand, single, block or cascade; bits 3-2 pick verify, write, read.
// R12 - Mode bit 5 picks address decrement, clear means increment.
// R13 - Mode bit 4 set makes terminal count reload the channel from its base copies.
// R14 - The second mode port does the same for channels 4-7.
// R15 - Software puts channel 4 in cascade mode since it carries the first group.
// R16 - An illegal transfer type is stored but the channel then performs no transfer.
`timescale 1ns/1ps
module idc_cfg #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [7:0]        dreq,
   input  wire logic [7:0]        terminal_count,
   output logic [7:0]             dack_n,
   output logic [7:0]             mem_wr_xfer,
   output logic [7:0]             mem_rd_xfer,
   output logic [7:0]             addr_down,
   output logic [7:0]             tc_reload
);
   logic [7:0]  dreq_m_q, dreq_s_q;
   logic [5:0]  widx, ridx_q;
   logic        wr_go, wmap, wr_lane, rmap;
   logic        wr_cmd1, wr_cmd2, wr_mode1, wr_mode2, wr_clr1, wr_clr2;
   logic        bvalid_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic        rot1_q, dis1_q, rot2_q, dis2_q;
   logic [47:0] mode_flat;
   logic [5:0]  mode_ch [8];
   logic [5:0]  bank_rd;
   logic [7:0]  elig, casc;
   logic [3:0]  req1, req2;
   logic        g1_v_q, g2_v_q, ar_go;
   logic [1:0]  g1_i_q, g2_i_q, last1_q, last2_q;
   logic [2:0]  g1_n, g2_n;
   logic [7:0]  grant, dack_n_q, wrx_q, rdx_q, down_q, reload_q;
   idc_pkg::idc_rd_state_t rd_st_q;

   ////////////////////////////////////////////////////////////////////////
   // Requests come from pins, so two flops before anything looks at them
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dreq_m_q <= 8'h00;
         dreq_s_q <= 8'h00;
      end else begin
         dreq_m_q <= dreq;
         dreq_s_q <= dreq_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write side: address and data are taken together in one handshake
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign s_axi_awready = s_axi_wvalid & ~bvalid_q;
   assign s_axi_wready  = s_axi_awvalid & ~bvalid_q;
   assign widx          = s_axi_awaddr[7:2];
   assign wmap = widx inside {idc_pkg::IDX_CMD1, idc_pkg::IDX_MODE1, idc_pkg::IDX_CLR1,
                              idc_pkg::IDX_CMD2, idc_pkg::IDX_MODE2, idc_pkg::IDX_CLR2};
   // Only byte lane 0 carries register data; other lanes are ignored
   assign wr_lane  = wr_go & wmap & s_axi_wstrb[0];
   assign wr_cmd1  = wr_lane && widx == idc_pkg::IDX_CMD1;
   assign wr_cmd2  = wr_lane && widx == idc_pkg::IDX_CMD2;
   assign wr_mode1 = wr_lane && widx == idc_pkg::IDX_MODE1;
   assign wr_mode2 = wr_lane && widx == idc_pkg::IDX_MODE2;
   assign wr_clr1  = wr_lane && widx == idc_pkg::IDX_CLR1;
   assign wr_clr2  = wr_lane && widx == idc_pkg::IDX_CLR2;

   // Write response one cycle after the handshake, held until bready
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= idc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wmap ? idc_pkg::RESP_OKAY : idc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   ////////////////////////////////////////////////////////////////////////
   // Command registers; polarity bits are not stored since the pins are fixed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rot1_q <= idc_pkg::CMD_RST; // R6
         dis1_q <= idc_pkg::CMD_RST;
      end else if (wr_clr1) begin
         rot1_q <= idc_pkg::CMD_RST; // R1
         dis1_q <= idc_pkg::CMD_RST;
      end else if (wr_cmd1) begin
         rot1_q <= s_axi_wdata[idc_pkg::CMD_ROT_BIT]; // R6
         dis1_q <= s_axi_wdata[idc_pkg::CMD_DIS_BIT]; // R7
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rot2_q <= idc_pkg::CMD_RST;
         dis2_q <= idc_pkg::CMD_RST;
      end else if (wr_clr2) begin
         rot2_q <= idc_pkg::CMD_RST;
         dis2_q <= idc_pkg::CMD_RST;
      end else if (wr_cmd2) begin
         rot2_q <= s_axi_wdata[idc_pkg::CMD_ROT_BIT]; // R8
         dis2_q <= s_axi_wdata[idc_pkg::CMD_DIS_BIT]; // R8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode words; the second port addresses entries 4-7
   idc_mode_bank #(.DEPTH(8), .AW(3), .DW(6)) u_bank (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .we        (wr_mode1 | wr_mode2),                  // R10 R14
      .waddr     ({wr_mode2, s_axi_wdata[1:0]}),         // R10 R14
      .wdata     (s_axi_wdata[7:2]),
      .re        (ar_go),
      .raddr     (s_axi_araddr[4:2]),
      .rdata_q   (bank_rd),
      .mode_flat (mode_flat)
   );

   // Per channel: eligibility, cascade flag, direction and reload
   for (genvar i = 0; i < 8; i++) begin : g_ch
      assign mode_ch[i] = mode_flat[i*6 +: 6];
      assign casc[i] = mode_ch[i][idc_pkg::MD_XM_LSB +: 2] == idc_pkg::IDC_CASCADE; // R11
      // Illegal type is kept but never competes for service unless the channel is in cascade mode
      assign elig[i] = dreq_s_q[i] & ~dis2_q & ((i < 4) ? ~dis1_q : 1'b1) // R5 R7 R9
                     & (casc[i] |
                        mode_ch[i][idc_pkg::MD_TYPE_LSB +: 2] != idc_pkg::IDC_ILLEGAL); // R16
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            dack_n_q[i] <= 1'b1;
            wrx_q[i]    <= 1'b0;
            rdx_q[i]    <= 1'b0;
            down_q[i]   <= 1'b0;
            reload_q[i] <= 1'b0;
         end else begin
            dack_n_q[i] <= ~grant[i]; // R4
            wrx_q[i] <= grant[i] && !casc[i] &&
                        mode_ch[i][idc_pkg::MD_TYPE_LSB +: 2] == idc_pkg::IDC_WRITE; // R11
            rdx_q[i] <= grant[i] && !casc[i] &&
                        mode_ch[i][idc_pkg::MD_TYPE_LSB +: 2] == idc_pkg::IDC_READ; // R11
            down_q[i]   <= mode_ch[i][idc_pkg::MD_DEC_BIT]; // R12
            reload_q[i] <= terminal_count[i] & mode_ch[i][idc_pkg::MD_AUTO_BIT]; // R13
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration: a grant is kept while its request stays up, then re-picked
   function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] start);
      logic [2:0] r;
      logic [1:0] k;
      r = 3'h0;
      for (int i = 3; i >= 0; i--) begin
         k = start + 2'(i);
         if (req[k]) begin
            r = {1'b1, k};
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] next_g(input logic [3:0] req, input logic cv,
                                         input logic [1:0] ci, input logic rot,
                                         input logic [1:0] last);
      logic [2:0] r;
      if (cv && req[ci]) begin
         r = {1'b1, ci};
      end else begin
         r = pick(req, rot ? last + 2'h1 : 2'h0); // R6
      end
      return r;
   endfunction

   // The whole first group shows up as channel 4 of the second group
   assign req1 = elig[3:0];
   assign req2 = {elig[7:5], casc[4] ? |req1 : elig[4]}; // R2
   assign g1_n = next_g(req1, g1_v_q, g1_i_q, rot1_q, last1_q);
   assign g2_n = next_g(req2, g2_v_q, g2_i_q, rot2_q, last2_q);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         g1_v_q <= 1'b0;
         g1_i_q <= 2'h0;
         g2_v_q <= 1'b0;
         g2_i_q <= 2'h0;
         last1_q <= 2'h0;
         last2_q <= 2'h0;
      end else begin
         {g1_v_q, g1_i_q} <= g1_n;
         {g2_v_q, g2_i_q} <= g2_n;
         // Rotation pointer follows the most recent winner
         if (g1_v_q) begin
            last1_q <= g1_i_q;
         end
         if (g2_v_q) begin
            last2_q <= g2_i_q;
         end
      end
   end

   // First group is acknowledged only when the second group grants its cascade
   always_comb begin
      grant = 8'h00;
      if (g2_v_q && g2_i_q == 2'h0 && casc[4]) begin
         grant[{1'b0, g1_i_q}] = g1_v_q; // R2
      end else if (g2_v_q) begin
         grant[{1'b1, g2_i_q}] = 1'b1;
      end
   end

   assign dack_n      = dack_n_q;
   assign mem_wr_xfer = wrx_q;
   assign mem_rd_xfer = rdx_q;
   assign addr_down   = down_q;
   assign tc_reload   = reload_q;

   ////////////////////////////////////////////////////////////////////////
   // Read side: take, fetch (mode bank answers), respond; two cycles to rvalid
   assign ar_go = s_axi_arvalid && rd_st_q == idc_pkg::IDC_RD_IDLE;
   assign s_axi_arready = rd_st_q == idc_pkg::IDC_RD_IDLE;
   // Write-only registers read as zero but are still mapped
   assign rmap = ridx_q inside {idc_pkg::IDX_CMD1, idc_pkg::IDX_MODE1, idc_pkg::IDX_CLR1,
                                idc_pkg::IDX_CMD2, idc_pkg::IDX_MODE2, idc_pkg::IDX_CLR2,
                                idc_pkg::IDX_STAT} || ridx_q[5:3] == idc_pkg::IDX_MRD_HI;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_st_q  <= idc_pkg::IDC_RD_IDLE;
         ridx_q   <= 6'h00;
         rvalid_q <= 1'b0;
         rresp_q  <= idc_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else begin
         case (rd_st_q)
            idc_pkg::IDC_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  ridx_q  <= s_axi_araddr[7:2];
                  rd_st_q <= idc_pkg::IDC_RD_FETCH;
               end
            end
            idc_pkg::IDC_RD_FETCH: begin
               rvalid_q <= 1'b1;
               rresp_q  <= rmap ? idc_pkg::RESP_OKAY : idc_pkg::RESP_SLVERR;
               rdata_q  <= 32'h0000_0000;
               if (ridx_q == idc_pkg::IDX_STAT) begin
                  rdata_q[idc_pkg::ST_ROT1] <= rot1_q;
                  rdata_q[idc_pkg::ST_ROT2] <= rot2_q;
                  rdata_q[idc_pkg::ST_DIS1] <= dis1_q;
                  rdata_q[idc_pkg::ST_DIS2] <= dis2_q;
                  rdata_q[idc_pkg::ST_GV1]  <= g1_v_q;
                  rdata_q[idc_pkg::ST_GV2]  <= g2_v_q;
                  rdata_q[idc_pkg::ST_DREQ +: 8] <= dreq_s_q;
               end else if (ridx_q[5:3] == idc_pkg::IDX_MRD_HI) begin
                  rdata_q[7:2] <= bank_rd; // Mode sits where it was written
               end
               rd_st_q <= idc_pkg::IDC_RD_RESP;
            end
            idc_pkg::IDC_RD_RESP: begin
               if (s_axi_rready) begin
                  rvalid_q <= 1'b0;
                  rd_st_q  <= idc_pkg::IDC_RD_IDLE;
               end
            end
            default: begin
               rvalid_q <= 1'b0;
               rd_st_q  <= idc_pkg::IDC_RD_IDLE;
            end
         endcase
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_clr1_clears_cmd: assert property (@(posedge clk_sys) disable iff (rst) // R1
      wr_clr1 |=> !rot1_q && !dis1_q) else $error("first command not cleared");
   a_cascade_req: assert property (@(posedge clk_sys) disable iff (rst) // R2
      casc[4] && |elig[3:0] |-> req2[0]) else $error("first group not cascaded");
   a_dack_low_grant: assert property (@(posedge clk_sys) disable iff (rst) // R4
      g2_v_q && g2_i_q == 2'h1 |=> !dack_n_q[5] && dack_n_q[7:6] == 2'h3)
      else $error("acknowledge not driven low");
   a_grant_needs_req: assert property (@(posedge clk_sys) disable iff (rst) // R5
      g2_v_q && g2_i_q == 2'h2 |-> $past(dreq_s_q[6])) else $error("grant without request");
   a_fixed_prio: assert property (@(posedge clk_sys) disable iff (rst) // R6
      !rot1_q && !g1_v_q && req1 == 4'hF |=> g1_v_q && g1_i_q == 2'h0)
      else $error("fixed priority not lowest first");
   a_grp1_off: assert property (@(posedge clk_sys) disable iff (rst) // R7
      dis1_q ##1 dis1_q |=> dack_n_q[3:0] == 4'hF) else $error("first group still served");
   a_cmd2_write: assert property (@(posedge clk_sys) disable iff (rst) // R8
      wr_cmd2 |=> dis2_q == $past(s_axi_wdata[2]) && rot2_q == $past(s_axi_wdata[4]))
      else $error("second command not stored");
   a_grp2_all_off: assert property (@(posedge clk_sys) disable iff (rst) // R9
      dis2_q ##1 dis2_q |=> dack_n_q == 8'hFF) else $error("channels served while off");
   a_mode1_store: assert property (@(posedge clk_sys) disable iff (rst) // R10
      wr_mode1 |=> mode_ch[{1'b0, $past(s_axi_wdata[1:0])}] == $past(s_axi_wdata[7:2]))
      else $error("first mode port not stored");
   a_mode2_store: assert property (@(posedge clk_sys) disable iff (rst) // R14
      wr_mode2 |=> mode_ch[{1'b1, $past(s_axi_wdata[1:0])}] == $past(s_axi_wdata[7:2]))
      else $error("second mode port not stored");
   a_write_type: assert property (@(posedge clk_sys) disable iff (rst) // R11
      wrx_q[5] |-> $past(mode_ch[5][1:0]) == 2'h1 && !$past(casc[5]))
      else $error("write transfer with wrong type");
   a_dir_follows: assert property (@(posedge clk_sys) disable iff (rst) // R12
      wr_mode1 && s_axi_wdata[1:0] == 2'h0 |=> ##1 addr_down[0] == $past(s_axi_wdata[5], 2))
      else $error("direction not applied");
   a_tc_reload: assert property (@(posedge clk_sys) disable iff (rst) // R13
      terminal_count[2] |=> tc_reload[2] == $past(mode_ch[2][2]))
      else $error("reload does not follow autoinit");
   a_illegal_idle: assert property (@(posedge clk_sys) disable iff (rst) // R16
      mode_ch[6][1:0] == 2'h3 && !casc[6] |-> !elig[6] && !wrx_q[6] && !rdx_q[6])
      else $error("illegal type served");
endmodule

//--- idc_isa_periph.sv
`timescale 1ns/1ps
module idc_isa_periph (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [7:0] want,
   input  wire logic [7:0] dack_n,
   output logic      [7:0] dreq
);
   logic [7:0] dreq_q;
   logic [7:0] served_q;

   assign dreq = dreq_q;
   // Request is active high; dropped once acknowledged, one transfer per request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dreq_q <= 8'h00;
      end else begin
         dreq_q <= want & ~served_q & dack_n;
      end
   end
   // Only a low acknowledge counts; want must fall before the next request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         served_q <= 8'h00;
      end else begin
         served_q <= want & (served_q | ~dack_n);
      end
   end
endmodule

//--- idc_mode_bank.sv
`timescale 1ns/1ps
module idc_mode_bank #(
   parameter int DEPTH = 8,
   parameter int AW    = 3,
   parameter int DW    = 6
) (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                we,
   input  wire logic [AW-1:0]       waddr,
   input  wire logic [DW-1:0]       wdata,
   input  wire logic                re,
   input  wire logic [AW-1:0]       raddr,
   output logic      [DW-1:0]       rdata_q,
   output logic      [DEPTH*DW-1:0] mode_flat
);
   logic [DW-1:0] mem_q [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // One mode word per channel; all words stay visible to the arbiter
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            mem_q[i] <= idc_pkg::MODE_RST;
         end else if (we && waddr == AW'(i)) begin
            mem_q[i] <= wdata;
         end
      end
      assign mode_flat[i*DW +: DW] = mem_q[i];
   end

   // Read port is registered and only moves when asked, so the bus sees a stable word
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (re) begin
         rdata_q <= mem_q[raddr];
      end
   end
endmodule

//--- idc_pkg.sv
package idc_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [5:0] IDX_CMD1  = 6'h08;
   localparam logic [5:0] IDX_MODE1 = 6'h0B;
   localparam logic [5:0] IDX_CLR1  = 6'h0D;
   localparam logic [5:0] IDX_CMD2  = 6'h10;
   localparam logic [5:0] IDX_MODE2 = 6'h16;
   localparam logic [5:0] IDX_CLR2  = 6'h1A;
   localparam logic [5:0] IDX_STAT  = 6'h20;
   localparam logic [2:0] IDX_MRD_HI = 3'h5;  // Indices 0x28..0x2F read channel modes

   // Command byte fields
   localparam int CMD_ROT_BIT = 4;
   localparam int CMD_DIS_BIT = 2;
   localparam logic CMD_RST = 1'b0;

   // Stored mode is write bits 7-2, so the fields sit two places lower
   localparam int MD_TYPE_LSB = 0;
   localparam int MD_AUTO_BIT = 2;
   localparam int MD_DEC_BIT  = 3;
   localparam int MD_XM_LSB   = 4;
   localparam int MD_SEL_W    = 2;
   localparam logic [5:0] MODE_RST = 6'h00;

   // Status register fields
   localparam int ST_ROT1 = 0;
   localparam int ST_ROT2 = 1;
   localparam int ST_DIS1 = 2;
   localparam int ST_DIS2 = 3;
   localparam int ST_GV1  = 4;
   localparam int ST_GV2  = 5;
   localparam int ST_DREQ = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      IDC_DEMAND  = 2'h0,
      IDC_SINGLE  = 2'h1,
      IDC_BLOCK   = 2'h2,
      IDC_CASCADE = 2'h3
   } idc_xmode_t;

   typedef enum logic [1:0] {
      IDC_VERIFY  = 2'h0,
      IDC_WRITE   = 2'h1,
      IDC_READ    = 2'h2,
      IDC_ILLEGAL = 2'h3
   } idc_xtype_t;

   typedef enum logic [1:0] {
      IDC_RD_IDLE  = 2'h0,
      IDC_RD_FETCH = 2'h1,
      IDC_RD_RESP  = 2'h3
   } idc_rd_state_t;
endpackage

//--- isa_dma_command_and_channel_mode_tb.sv
`timescale 1ns/1ps
module isa_dma_command_and_channel_mode_tb;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, want = 8'h00, tcnt = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  dreq, dack_n, mwr, mrd, adown, tcrl;
   int          fail_count = 0, num_checks = 0;

   idc_cfg idc_cfg_i (
      .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dreq(dreq),
      .terminal_count(tcnt), .dack_n(dack_n), .mem_wr_xfer(mwr), .mem_rd_xfer(mrd),
      .addr_down(adown), .tc_reload(tcrl));
   idc_isa_periph idc_isa_periph_i (
      .clk_sys(clk_sys), .rst(rst), .want(want), .dack_n(dack_n), .dreq(dreq));

   // 10 MHz system clock
   always #50 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: pin got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: bus got %h exp %h", $time, got, exp);
      end
   endtask
   // Handshakes sampled at the falling edge, where every input is already settled
   task automatic axw(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
      logic ah, wh, bh;
      int   n;
      bh = 1'b0;
      n = 0;
      r = 2'h1;
      @(posedge clk_sys);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bh && n < 50) begin
         @(negedge clk_sys);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bready & bvalid;
         if (bh) r = bresp;
         @(posedge clk_sys);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) bready <= 1'b0;
         n++;
      end
      chk_pin({7'h0, bh}, 8'h01);
   endtask
   task automatic axr(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      int   n;
      rh = 1'b0;
      n = 0;
      @(posedge clk_sys);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rh && n < 50) begin
         @(negedge clk_sys);
         ah = arvalid & arready;
         rh = rready & rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk_sys);
         if (ah) arvalid <= 1'b0;
         if (rh) rready <= 1'b0;
         n++;
      end
      chk_pin({7'h0, rh}, 8'h01);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [1:0] r;
      axw(idx, d, r);
      chk_bus({30'h0, r}, {30'h0, idc_pkg::RESP_OKAY});
   endtask
   task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axr(idx, d, r);
      chk_bus(d, exp);
      chk_bus({30'h0, r}, {30'h0, idc_pkg::RESP_OKAY});
   endtask
   // Raise one request and wait a bounded time for its acknowledge
   task automatic req(input int ch);
      int n;
      n = 0;
      @(posedge clk_sys);
      want[ch] <= 1'b1;
      while (dack_n[ch] !== 1'b0 && n < 12) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   task automatic rel();
      @(posedge clk_sys);
      want <= 8'h00;
      repeat (8) @(posedge clk_sys);
   endtask
   // Raise several requests in one edge and stop while the first acknowledge stands
   task automatic reqs(input logic [7:0] m);
      @(posedge clk_sys);
      want <= m;
      repeat (6) @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk_pin(dack_n, 8'hFF);
      chk_pin(mwr | mrd | adown | tcrl, 8'h00);
      rdc(idc_pkg::IDX_STAT, 32'h0);
      rdc(idc_pkg::IDX_CMD1, 32'h0);
   endtask
   task automatic t_mode();
      logic [7:0] d;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         d = {c[1:0], c[0], c[2], 1'b0, c[1], c[1:0]};
         wr(c[2] ? idc_pkg::IDX_MODE2 : idc_pkg::IDX_MODE1, d);
         rdc({idc_pkg::IDX_MRD_HI, c}, {24'h0, d[7:2], 2'b00});
         chk_pin({7'h0, adown[c]}, {7'h0, c[0]});
      end
   endtask
   task automatic t_cmd();
      logic [1:0] r;
      wr(idc_pkg::IDX_CMD1, 8'h14);
      rdc(idc_pkg::IDX_STAT, 32'h05);
      wr(idc_pkg::IDX_CMD2, 8'h14);
      rdc(idc_pkg::IDX_STAT, 32'h0F);
      wr(idc_pkg::IDX_CLR1, 8'h00);
      rdc(idc_pkg::IDX_STAT, 32'h0A);
      wr(idc_pkg::IDX_CLR2, 8'h00);
      axw(6'h3F, 8'h14, r);
      chk_bus({30'h0, r}, {30'h0, idc_pkg::RESP_SLVERR});
      rdc(idc_pkg::IDX_STAT, 32'h0);
   endtask
   task automatic t_grant();
      wr(idc_pkg::IDX_MODE2, 8'h45);
      wr(idc_pkg::IDX_CMD2, 8'hC0);
      req(5);
      chk_pin(dack_n, 8'hDF);
      chk_pin(mwr, 8'h20);
      rel();
   endtask
   // Two requests at once: lowest wins when fixed, the one after the last winner when rotating
   task automatic t_prio();
      reqs(8'h60);
      chk_pin(dack_n, 8'hDF);
      rel();
      wr(idc_pkg::IDX_CMD2, 8'h10);
      req(5);
      rel();
      reqs(8'h60);
      chk_pin(dack_n, 8'hBF);
      rel();
      wr(idc_pkg::IDX_CMD2, 8'h00);
   endtask
   task automatic t_cascade();
      wr(idc_pkg::IDX_MODE2, 8'hC0);
      wr(idc_pkg::IDX_MODE1, 8'h49);
      wr(idc_pkg::IDX_CLR1, 8'h00);
      req(1);
      chk_pin(dack_n, 8'hFD);
      chk_pin(mrd, 8'h02);
      rel();
      wr(idc_pkg::IDX_CMD2, 8'h04);
      req(1);
      chk_pin(dack_n, 8'hFF);
      rel();
      req(5);
      chk_pin(dack_n, 8'hFF);
      rel();
      wr(idc_pkg::IDX_CMD2, 8'h00);
      wr(idc_pkg::IDX_CMD1, 8'h04);
      req(1);
      chk_pin(dack_n, 8'hFF);
      rel();
      req(5);
      chk_pin(dack_n, 8'hDF);
      rel();
      wr(idc_pkg::IDX_CLR1, 8'h00);
   endtask
   task automatic t_illegal();
      wr(idc_pkg::IDX_MODE2, 8'h4E);
      req(6);
      chk_pin(dack_n, 8'hFF);
      chk_pin(mwr | mrd, 8'h00);
      rel();
   endtask
   task automatic t_tc();
      wr(idc_pkg::IDX_MODE2, 8'h53);
      wr(idc_pkg::IDX_MODE1, 8'h40);
      @(posedge clk_sys);
      tcnt <= 8'h81;
      @(posedge clk_sys);
      tcnt <= 8'h00;
      #1 chk_pin(tcrl, 8'h80);
      @(posedge clk_sys);
      #1 chk_pin(tcrl, 8'h00);
   endtask
   // Hardware reset in mid-run clears both command registers and the mode words
   task automatic t_hwrst();
      wr(idc_pkg::IDX_CMD1, 8'h14);
      wr(idc_pkg::IDX_CMD2, 8'h14);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      chk_pin(dack_n, 8'hFF);
      rdc(idc_pkg::IDX_STAT, 32'h0);
      rdc({idc_pkg::IDX_MRD_HI, 3'h5}, 32'h0);
   endtask
   task automatic end_sim();
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence; reset released after four edges
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_mode();
      t_cmd();
      t_grant();
      t_prio();
      t_cascade();
      t_illegal();
      t_tc();
      t_hwrst();
      end_sim();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #2000000;
      fail_count++;
      end_sim();
   end
endmodule
